// *** include/cftq_pkg.sv ***
/*
 Shared constants for the transmit queue configuration slice:
 register byte offsets, field positions, reset values and encodings.
 Assumes a 32-bit APB register bus with one register per aligned word.
*/
package cftq_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_ATT_LOW   = 8'h00;
    localparam logic [7:0] OFS_ATT_HIGH  = 8'h04;
    localparam logic [7:0] OFS_REQ_LOW   = 8'h08;
    localparam logic [7:0] OFS_REQ_HIGH  = 8'h0C;
    localparam logic [7:0] OFS_BASE_LOW  = 8'h10;
    localparam logic [7:0] OFS_BASE_HIGH = 8'h14;
    localparam logic [7:0] OFS_TXQ_HIGH  = 8'h18;
    localparam logic [7:0] OFS_CTRL      = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h28;
    // field positions in the queue configuration and control words
    localparam int PLS_LSB = 13;
    localparam int DEP_LSB = 8;
    localparam int RTY_LSB = 5;
    localparam int PRI_LSB = 0;
    localparam int CTRL_RRE_BIT = 0;
    localparam int CTRL_MODE_LSB = 8;
    // reset values and encodings
    localparam logic [1:0] RTY_RESET     = 2'h3;
    localparam logic [1:0] RTY_NONE      = 2'h0;
    localparam logic [1:0] RTY_THREE     = 2'h1;
    localparam logic [2:0] MODE_CONFIG   = 3'h4;
    localparam logic [1:0] BASE_ALIGN    = 2'h0;
    localparam logic [3:0] RETRY_LIMIT3  = 4'h3;
    localparam int         NOBJ          = 8;
    // interrupt status bits
    localparam int IRQ_REQ_DONE = 0;
    localparam int IRQ_ATT_SET  = 1;
    localparam int IRQ_W        = 2;
endpackage

// *** logic/cftq_core.sv ***
/*
 Transmit request, attempt summary, message memory base and queue
 configuration registers with an APB slave and one level interrupt.
 Assumes the protocol engine reports per-object completion and the
 attempt-exhausted flags, and the mode logic supplies the mode status.
*/
// Register access over APB and the register offsets were left to the implementer.
// Function
// [R1] eight-bit read-only attempt exhausted summary
// [R2] summary only mirrors flags, cleared elsewhere
// [R3] bits eight to thirty-one read zero
// [R4] set request starts transmit, hardware clears
// [R5] writes never abort pending transmissions
// [R6] receive objects ignore request set
// [R7] bit zero belongs to transmit queue
// [R8] request bits software set, hardware clear
// [R9] thirty-two bit base address, two halves
// [R10] base address low two bits zero
// [R11] payload size code maps to bytes
// [R12] depth equals field value plus one
// [R13] retry field none, three or unlimited
// [R14] retry limit only with restricted enable
// [R15] priority five bits, all ones highest
// [R16] size and depth writable only configuring
// [R17] writing zero leaves request bits unchanged
// [R18] reset retry code three, others zero
`timescale 1ns/1ps
module cftq_core
    import cftq_pkg::*;
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // protocol engine side
    input  wire logic [cftq_pkg::NOBJ-1:0]  obj_tx_dir,
    input  wire logic [cftq_pkg::NOBJ-1:0]  obj_all_sent,
    input  wire logic [cftq_pkg::NOBJ-1:0]  obj_attempt_flag,
    input  wire logic [2:0]                 operating_mode_status,
    output logic [cftq_pkg::NOBJ-1:0]       send_request,
    output logic [31:0]                     message_memory_base,
    output logic [6:0]                      queue_payload_bytes,
    output logic [5:0]                      queue_depth_msgs,
    output logic                            queue_retry_unlimited,
    output logic [3:0]                      queue_retry_limit,
    output logic [4:0]                      transmit_priority,
    // interrupt
    output logic                            irq
);
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic [7:0]  req;
        logic [7:0]  att;
        logic [31:0] base;
        logic [2:0]  payload_size_sel;
        logic [4:0]  queue_depth_sel;
        logic [1:0]  retry_attempts_sel;
        logic [4:0]  prio;
        logic        restricted_retry_enable;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] ien;
        logic        irq;
        logic [6:0]  pl_bytes;
        logic [5:0]  depth;
        logic        unlim;
        logic [3:0]  limit;
    } cftq_state_t;

    cftq_state_t st_reg;
    cftq_state_t st_next;

    // payload size code to byte count
    function automatic logic [6:0] pl_decode(input logic [2:0] c);
        unique case (c)
            3'h0: pl_decode = 7'h08;
            3'h1: pl_decode = 7'h0C;
            3'h2: pl_decode = 7'h10;
            3'h3: pl_decode = 7'h14;
            3'h4: pl_decode = 7'h18;
            3'h5: pl_decode = 7'h20;
            3'h6: pl_decode = 7'h30;
            3'h7: pl_decode = 7'h40;
        endcase
    endfunction

    logic access;
    logic wr;
    logic known;
    logic [7:0] set_req;
    logic [7:0] done_req;

    // one wait state; a write commits at the edge that ends the access
    assign access = psel && penable && !st_reg.pready;
    assign wr     = psel && penable && st_reg.pready && pwrite;
    assign known  = paddr inside {OFS_ATT_LOW, OFS_ATT_HIGH, OFS_REQ_LOW,
        OFS_REQ_HIGH, OFS_BASE_LOW, OFS_BASE_HIGH, OFS_TXQ_HIGH,
        OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR};
    // only ones set, and only on transmit objects
    assign set_req  = (wr && paddr == OFS_REQ_LOW) ?
        (pwdata[7:0] & obj_tx_dir) : 8'h00; // [R6] [R17]
    assign done_req = st_reg.req & obj_all_sent;

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.pready  = access;
        st_next.pslverr = access && !known;
        st_next.prdata  = 32'h0000_0000;
        // hardware clear only; set wins over same-cycle completion
        st_next.req = (st_reg.req & ~obj_all_sent) | set_req; // [R4] [R5] [R7] [R8]
        st_next.att = obj_attempt_flag; // [R1] [R2]
        if (wr) begin
            unique case (paddr)
                OFS_BASE_LOW: begin
                    st_next.base[15:0] = {pwdata[15:2], BASE_ALIGN}; // [R10]
                end
                OFS_BASE_HIGH: begin
                    st_next.base[31:16] = pwdata[15:0]; // [R9]
                end
                OFS_TXQ_HIGH: begin
                    // size and depth frozen outside configuration mode
                    if (operating_mode_status == MODE_CONFIG) begin // [R16]
                        st_next.payload_size_sel = pwdata[PLS_LSB +: 3];
                        st_next.queue_depth_sel  = pwdata[DEP_LSB +: 5];
                    end
                    st_next.retry_attempts_sel = pwdata[RTY_LSB +: 2];
                    st_next.prio = pwdata[PRI_LSB +: 5]; // [R15]
                end
                OFS_CTRL: begin
                    st_next.restricted_retry_enable = pwdata[CTRL_RRE_BIT];
                end
                OFS_IRQ_EN: begin
                    st_next.ien = pwdata[IRQ_W-1:0];
                end
                OFS_IRQ_CLR: begin
                    st_next.ist = st_reg.ist & ~pwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // events set after the clear so a coincident event survives
        if (|done_req) begin
            st_next.ist[IRQ_REQ_DONE] = 1'b1;
        end
        if (|(obj_attempt_flag & ~st_reg.att)) begin
            st_next.ist[IRQ_ATT_SET] = 1'b1;
        end
        if (access && !pwrite) begin
            unique case (paddr)
                OFS_ATT_LOW:   st_next.prdata = {24'h000000, st_reg.att}; // [R3]
                OFS_REQ_LOW:   st_next.prdata = {24'h000000, st_reg.req}; // [R3]
                OFS_BASE_LOW:  st_next.prdata = {16'h0000, st_reg.base[15:0]};
                OFS_BASE_HIGH: st_next.prdata = {16'h0000, st_reg.base[31:16]};
                OFS_TXQ_HIGH:  st_next.prdata = {16'h0000,
                    st_reg.payload_size_sel, st_reg.queue_depth_sel, 1'b0,
                    st_reg.retry_attempts_sel, st_reg.prio};
                OFS_CTRL:      st_next.prdata = {21'h000000,
                    operating_mode_status, 7'h00,
                    st_reg.restricted_retry_enable};
                OFS_IRQ_STAT:  st_next.prdata = {30'h0, st_reg.ist};
                OFS_IRQ_EN:    st_next.prdata = {30'h0, st_reg.ien};
                default:       st_next.prdata = 32'h0000_0000;
            endcase
        end
        // decoded queue settings for the engine
        st_next.pl_bytes = pl_decode(st_reg.payload_size_sel); // [R11]
        st_next.depth = {1'b0, st_reg.queue_depth_sel} + 6'h01; // [R12]
        // limit applies only under restricted retransmission
        if (!st_reg.restricted_retry_enable) begin // [R14]
            st_next.unlim = 1'b1;
            st_next.limit = 4'h0;
        end else begin
            st_next.unlim = st_reg.retry_attempts_sel[1]; // [R13]
            st_next.limit = (st_reg.retry_attempts_sel == RTY_THREE) ?
                RETRY_LIMIT3 : 4'h0; // [R13]
        end
        st_next.irq = |(st_next.ist & st_next.ien);
        if (sys_rst) begin
            st_next = '0;
            st_next.retry_attempts_sel = RTY_RESET; // [R18]
            st_next.pl_bytes = pl_decode(3'h0);
            st_next.depth = 6'h01;
            st_next.unlim = 1'b1;
        end
    end

    // single state register, synchronous reset folded in above
    always_ff @(posedge core_clk) begin
        st_reg <= st_next;
    end

    assign pready                = st_reg.pready;
    assign prdata                = st_reg.prdata;
    assign pslverr               = st_reg.pslverr;
    assign send_request          = st_reg.req;
    assign message_memory_base   = st_reg.base;
    assign queue_payload_bytes   = st_reg.pl_bytes;
    assign queue_depth_msgs      = st_reg.depth;
    assign queue_retry_unlimited = st_reg.unlim;
    assign queue_retry_limit     = st_reg.limit;
    assign transmit_priority     = st_reg.prio;
    assign irq                   = st_reg.irq;

    // request set by a write lands one cycle later
    property p_req_set;
        @(posedge core_clk) disable iff (sys_rst)
        (wr && paddr == OFS_REQ_LOW && pwdata[0] && obj_tx_dir[0])
            |=> send_request[0];
    endproperty
    a_req_set: assert property (p_req_set) // [R7]
        else $error("queue request not set");

    property p_rx_ignore;
        @(posedge core_clk) disable iff (sys_rst)
        (!send_request[7] && !obj_tx_dir[7]) |=> !send_request[7];
    endproperty
    a_rx_ignore: assert property (p_rx_ignore) // [R6]
        else $error("receive object took a request");

    property p_no_abort;
        @(posedge core_clk) disable iff (sys_rst)
        (send_request[1] && !obj_all_sent[1]) |=> send_request[1];
    endproperty
    a_no_abort: assert property (p_no_abort) // [R5]
        else $error("request dropped without completion");

    property p_hw_clear;
        @(posedge core_clk) disable iff (sys_rst)
        (send_request[2] && obj_all_sent[2] && !set_req[2])
            |=> !send_request[2];
    endproperty
    a_hw_clear: assert property (p_hw_clear) // [R4]
        else $error("request not cleared on completion");

    property p_base_align;
        @(posedge core_clk) disable iff (sys_rst)
        message_memory_base[1:0] == BASE_ALIGN;
    endproperty
    a_base_align: assert property (p_base_align) // [R10]
        else $error("base address not word aligned");

    property p_cfg_lock;
        @(posedge core_clk) disable iff (sys_rst)
        (operating_mode_status != MODE_CONFIG)
            |=> $stable(st_reg.queue_depth_sel);
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) // [R16]
        else $error("depth changed outside configuration");

    property p_depth;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 queue_depth_msgs == {1'b0, $past(st_reg.queue_depth_sel)} + 6'h01;
    endproperty
    a_depth: assert property (p_depth) // [R12]
        else $error("depth decode wrong");

    property p_retry;
        @(posedge core_clk) disable iff (sys_rst)
        (!st_reg.restricted_retry_enable) |=> queue_retry_unlimited;
    endproperty
    a_retry: assert property (p_retry) // [R14]
        else $error("retry limit applied while unrestricted");

    property p_summary;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 st_reg.att == $past(obj_attempt_flag);
    endproperty
    a_summary: assert property (p_summary) // [R1]
        else $error("summary does not mirror flags");

    // the upper attempt half has no flags behind it
    property p_att_high_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (access && !pwrite && paddr == OFS_ATT_HIGH)
            |=> prdata == 32'h0000_0000;
    endproperty
    a_att_high_zero: assert property (p_att_high_zero) // [R3]
        else $error("attempt high half not zero");

    // a zero in the write leaves the request as it was
    property p_req_keep;
        @(posedge core_clk) disable iff (sys_rst)
        (wr && paddr == OFS_REQ_LOW && !pwdata[4] && !obj_all_sent[4])
            |=> send_request[4] == $past(send_request[4]);
    endproperty
    a_req_keep: assert property (p_req_keep) // [R17]
        else $error("zero write changed a request");

    // nothing but a register write raises a request
    property p_req_sw_set;
        @(posedge core_clk) disable iff (sys_rst)
        (!send_request[5] && !(wr && paddr == OFS_REQ_LOW))
            |=> !send_request[5];
    endproperty
    a_req_sw_set: assert property (p_req_sw_set) // [R8]
        else $error("request rose without a write");

    // largest payload code gives the largest frame
    property p_payload_max;
        @(posedge core_clk) disable iff (sys_rst)
        (st_reg.payload_size_sel == 3'h7)
            |=> queue_payload_bytes == 7'h40;
    endproperty
    a_payload_max: assert property (p_payload_max) // [R11]
        else $error("payload decode wrong");

    // code one limits to three retries under restriction
    property p_limit_three;
        @(posedge core_clk) disable iff (sys_rst)
        (st_reg.restricted_retry_enable && st_reg.retry_attempts_sel == RTY_THREE)
            |=> (queue_retry_limit == RETRY_LIMIT3 && !queue_retry_unlimited);
    endproperty
    a_limit_three: assert property (p_limit_three) // [R13]
        else $error("three retry limit not reported");

    // code zero turns retransmission off under restriction
    property p_retry_none;
        @(posedge core_clk) disable iff (sys_rst)
        (st_reg.restricted_retry_enable && st_reg.retry_attempts_sel == RTY_NONE)
            |=> (queue_retry_limit == 4'h0 && !queue_retry_unlimited);
    endproperty
    a_retry_none: assert property (p_retry_none) // [R13]
        else $error("retransmission not disabled");

    // priority is taken in any mode
    property p_prio_write;
        @(posedge core_clk) disable iff (sys_rst)
        (wr && paddr == OFS_TXQ_HIGH)
            |=> transmit_priority == $past(pwdata[PRI_LSB +: 5]);
    endproperty
    a_prio_write: assert property (p_prio_write) // [R15]
        else $error("priority write lost");

    // upper base half follows the write
    property p_base_high;
        @(posedge core_clk) disable iff (sys_rst)
        (wr && paddr == OFS_BASE_HIGH)
            |=> message_memory_base[31:16] == $past(pwdata[15:0]);
    endproperty
    a_base_high: assert property (p_base_high) // [R9]
        else $error("base high write lost");

    // payload size frozen outside configuration mode
    property p_size_lock;
        @(posedge core_clk) disable iff (sys_rst)
        (operating_mode_status != MODE_CONFIG)
            |=> $stable(st_reg.payload_size_sel);
    endproperty
    a_size_lock: assert property (p_size_lock) // [R16]
        else $error("size changed outside configuration");

    // no limit reported while retries are unrestricted
    property p_limit_off;
        @(posedge core_clk) disable iff (sys_rst)
        (!st_reg.restricted_retry_enable) |=> queue_retry_limit == 4'h0;
    endproperty
    a_limit_off: assert property (p_limit_off) // [R14]
        else $error("limit reported while unrestricted");

    // deepest code gives thirty-two messages
    property p_depth_max;
        @(posedge core_clk) disable iff (sys_rst)
        (st_reg.queue_depth_sel == 5'h1F) |=> queue_depth_msgs == 6'h20;
    endproperty
    a_depth_max: assert property (p_depth_max) // [R12]
        else $error("deepest queue decode wrong");

    // a finished request always leaves a status bit behind
    property p_done_irq;
        @(posedge core_clk) disable iff (sys_rst)
        (|(send_request & obj_all_sent)) |=> st_reg.ist[IRQ_REQ_DONE];
    endproperty
    a_done_irq: assert property (p_done_irq) // [R4]
        else $error("completion status not set");
endmodule

// *** verif/can_fd_transmit_queue_config_tb.sv ***
/*
 Self-checking bench for cftq_core: APB master, read scoreboard.
 Assumes the engine stand-in and the design package.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end
module can_fd_transmit_queue_config_tb;
    import cftq_pkg::*;
    logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr, queue_retry_unlimited, irq;
    logic [7:0]  paddr = 8'h00, obj_all_sent, send_request, f;
    logic [7:0]  obj_tx_dir = 8'h7F, obj_attempt_flag = 0, go_mask = 0;
    logic [31:0] pwdata = 0, prdata, message_memory_base, r, v, seed = 44;
    logic [2:0]  operating_mode_status = 3'h4;
    logic [6:0]  queue_payload_bytes;
    logic [6:0]  pl[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
    logic [5:0]  queue_depth_msgs;
    logic [3:0]  queue_retry_limit;
    logic [4:0]  transmit_priority;
    logic [32:0] exq[$], e;
    int          bad_count = 0, n_checks = 0, cyc = 0;
    always #12.5 core_clk = ~core_clk;
    cftq_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .obj_tx_dir(obj_tx_dir),
        .obj_all_sent(obj_all_sent), .obj_attempt_flag(obj_attempt_flag),
        .operating_mode_status(operating_mode_status),
        .send_request(send_request),
        .message_memory_base(message_memory_base),
        .queue_payload_bytes(queue_payload_bytes),
        .queue_depth_msgs(queue_depth_msgs),
        .queue_retry_unlimited(queue_retry_unlimited),
        .queue_retry_limit(queue_retry_limit),
        .transmit_priority(transmit_priority), .irq(irq));
    cftq_engine_model eng (.core_clk(core_clk), .sys_rst(sys_rst),
        .send_request(send_request), .go_mask(go_mask),
        .obj_all_sent(obj_all_sent));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer; reads leave their expectation in the queue
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [32:0] x);
        if (!w) exq.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {1'b0, x});
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // read monitor: oldest note against what the slave returns
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exq.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        rd(OFS_TXQ_HIGH, 32'h0000_0060);
        rd(OFS_REQ_LOW, 32'h0);
        `CHK("bytes", 7'd8, queue_payload_bytes)
        `CHK("depth", 6'd1, queue_depth_msgs)
        $display("test reset done");
        r = xs();
        wr(OFS_BASE_LOW, 32'hFFFF_FFFF);
        wr(OFS_BASE_HIGH, r);
        rd(OFS_BASE_LOW, 32'h0000_FFFC);
        rd(OFS_BASE_HIGH, {16'h0, r[15:0]});
        `CHK("base", {r[15:0], 16'hFFFC}, message_memory_base)
        $display("test base done");
        // every payload code; depth and priority from 3 to 31 in steps of four
        for (int i = 0; i < 8; i++) begin
            v = {16'h0, 3'(i), 5'(i * 4 + 3), 3'b011, 5'(i * 4 + 3)};
            wr(OFS_TXQ_HIGH, v);
            rd(OFS_TXQ_HIGH, v);
            `CHK("bytes", pl[i], queue_payload_bytes)
            `CHK("depth", 6'(i * 4 + 4), queue_depth_msgs)
            `CHK("prio", 5'(i * 4 + 3), transmit_priority)
        end
        operating_mode_status <= 3'h0;
        wr(OFS_TXQ_HIGH, 32'h0);
        rd(OFS_TXQ_HIGH, 32'h0000_FF00);
        $display("test config done");
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                wr(OFS_CTRL, 32'(m));
                wr(OFS_TXQ_HIGH, 32'(c) << RTY_LSB);
                tick(2);
                `CHK("unl", !(m == 1 && c < 2), queue_retry_unlimited)
                `CHK("lim", (m == 1 && c == 1) ? 4'h3 : 4'h0,
                    queue_retry_limit)
            end
        end
        $display("test retry done");
        // object 7 is a receive object; the engine stalls at first
        wr(OFS_REQ_LOW, 32'hFFFF_FFFF);
        rd(OFS_REQ_LOW, 32'h7F);
        `CHK("req", 8'h7F, send_request)
        wr(OFS_REQ_LOW, 32'h0);
        rd(OFS_REQ_LOW, 32'h7F);
        rd(OFS_REQ_HIGH, 32'h0);
        go_mask <= 8'h01;
        tick(12);
        rd(OFS_REQ_LOW, 32'h7E);
        go_mask <= 8'hFE;
        tick(12);
        rd(OFS_REQ_LOW, 32'h0);
        `CHK("req", 8'h00, send_request)
        $display("test request done");
        f = 8'(xs()) | 8'h01;
        obj_attempt_flag <= f;
        tick(2);
        rd(OFS_ATT_LOW, {24'h0, f});
        wr(OFS_ATT_LOW, 32'h0);
        rd(OFS_ATT_LOW, {24'h0, f});
        rd(OFS_ATT_HIGH, 32'h0);
        rd(OFS_IRQ_STAT, 32'h3);
        `CHK("irq", 1'b0, irq)
        wr(OFS_IRQ_EN, 32'h2);
        tick(2);
        `CHK("irq", 1'b1, irq)
        wr(OFS_IRQ_CLR, 32'h3);
        tick(2);
        `CHK("irq", 1'b0, irq)
        rd(OFS_IRQ_STAT, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0});
        $display("test irq done");
        finish_test();
    end
endmodule

// *** verif/cftq_engine_model.sv ***
/*
 Stand-in for the protocol engine: finishes requested objects.
 Assumes the core_clk domain and a synchronous active high reset.
*/
`timescale 1ns/1ps
module cftq_engine_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // request side
    input  wire logic [7:0] send_request,
    input  wire logic [7:0] go_mask,
    output logic      [7:0] obj_all_sent
);
    logic [3:0] wait_cnt;
    // gated by go_mask so the bench can stall a request indefinitely
    always @(posedge core_clk) begin
        obj_all_sent <= 8'h00;
        if (sys_rst || (send_request & go_mask) == 8'h00) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt == 4'h6) begin
            obj_all_sent <= send_request & go_mask;
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
